// ### design/mtbc_pkg.sv
// constants and types of the maintenance, test and breaker control block
// Function
// - three maintenance settings: off, trips, blocked
// - blocked setting suppresses every output contact
// - LEDs still follow crossed thresholds when blocked
// - menu maintenance reverts to off after 10 minutes
// - input-held maintenance has no time limit
// - maintenance ends on input low, command, power-loss
// - maintenance selectable from input, port, panel
// - modbus reporting blocked, iec103 reporting flagged
// - maintenance state available for LED mapping
// - test pattern has one bit per contact
// - apply test closes selected contacts for test time
// - functional test trips element, nothing if disabled
// - end code 0 on trip, 1 after pulse
// - only tested stage sees doubled simulated current
// - thermal state cleared after thermal replica test
// - fault records use measured field currents
// - manual trip if closed, close if open
// - close order delayed by close delay
// - open and close pulses have own lengths
// - protection trip cancels a close in progress
// - breaker healthy must arrive before timeout, else lockout
package mtbc_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned MAINT_LIMIT_MIN = 10;
  localparam longint unsigned MAINT_LIMIT_CYC =
    longint'(MAINT_LIMIT_MIN) * 60 * CLK_HZ;
  localparam logic [1:0] MAINT_OFF   = 2'h0;
  localparam logic [1:0] MAINT_TRIPS = 2'h1;
  localparam logic [1:0] MAINT_BLOCK = 2'h2;
  localparam logic [1:0] MAINT_RSVD  = 2'h3;  // unused code, read as off
  localparam logic       FEND_TRIP   = 1'h0;
  localparam logic       FEND_TIME   = 1'h1;
  localparam logic       PROTO_MODBUS = 1'h0;
  localparam logic       PROTO_IEC103 = 1'h1;
  typedef enum {CB_IDLE, CB_WAIT_HEALTHY, CB_CLOSE_DELAY, CB_CLOSE_PULSE,
                CB_OPEN_PULSE, CB_LOCKOUT} mtbc_cb_state_t;
endpackage

// ### design/mtbc_top.sv
// maintenance mode, output and functional tests, manual breaker control
`timescale 1ns/10ps
module mtbc_top
  import mtbc_pkg::*;
#(
  parameter int          NUM_OUT   = 7,
  parameter int          NUM_ELEM  = 8,
  parameter int          TW        = 32,
  parameter logic [39:0] MAINT_CYC = 40'(MAINT_LIMIT_CYC)
) (
  input  wire logic                core_clk_i,           // 25 MHz clock
  input  wire logic                rst_i,                // sync reset, high
  input  wire logic                maint_in_assigned_i,  // logic input mapped
  input  wire logic                maint_in_i,           // logic input level
  input  wire logic                maint_set_stb_i,      // panel/port write
  input  wire logic [1:0]          maint_set_val_i,      // written setting
  input  wire logic                proto_i,              // rear protocol
  input  wire logic [NUM_OUT-1:0]  out_func_i,           // protection outputs
  input  wire logic [NUM_ELEM-1:0] led_func_i,           // crossed thresholds
  input  wire logic [NUM_OUT-1:0]  test_pattern_i,       // contact selection
  input  wire logic [TW-1:0]       test_time_i,          // test time, cycles
  input  wire logic                apply_test_i,         // apply test pulse
  input  wire logic [NUM_ELEM-1:0] elem_enable_i,        // element enabled
  input  wire logic [$clog2(NUM_ELEM)-1:0] ftest_sel_i,  // tested element
  input  wire logic                ftest_end_i,          // end code
  input  wire logic                ftest_go_i,           // operate pulse
  input  wire logic                elem_trip_i,          // tested element trip
  input  wire logic                prot_trip_i,          // protection trip
  input  wire logic                man_trip_i,           // manual trip pulse
  input  wire logic                man_close_i,          // manual close pulse
  input  wire logic                breaker_closed_aux_in_i, // aux closed
  input  wire logic                breaker_open_aux_in_i,   // aux open
  input  wire logic                healthy_assigned_i,   // healthy mapped
  input  wire logic                breaker_healthy_in_i, // breaker healthy
  input  wire logic                lockout_clr_i,        // clear lockout
  input  wire logic [TW-1:0]       close_delay_i,        // close delay, cycles
  input  wire logic [TW-1:0]       open_pulse_length_i,  // open pulse, cycles
  input  wire logic [TW-1:0]       close_pulse_length_i, // close pulse, cycles
  input  wire logic [TW-1:0]       breaker_healthy_timeout_i, // cycles
  output logic [1:0]               maint_mode_o,         // effective setting
  output logic                     maint_active_o,       // for LED mapping
  output logic                     report_en_o,          // scada reporting
  output logic                     report_maint_flag_o,  // iec103 marker
  output logic [NUM_OUT-1:0]       contact_o,            // output contacts
  output logic [NUM_ELEM-1:0]      led_o,                // LEDs
  output logic [NUM_ELEM-1:0]      sim_elem_o,           // stage on sim current
  output logic                     field_rec_o,          // records use field
  output logic                     thermal_clr_o,        // thermal to 0 pulse
  output logic                     breaker_open_command_out_o,  // trip order
  output logic                     breaker_close_command_out_o, // close order
  output logic                     cb_alarm_o            // healthy lockout
);
  initial begin
    // one-hot stage select needs two elements; timers need a zero and a last
    if (NUM_OUT < 1 || NUM_ELEM < 2 || TW < 2 || MAINT_CYC == '0) $error("bad parameters");
  end
  localparam logic [$clog2(NUM_ELEM)-1:0] THERMAL_IDX = '0;

  // one step of a down counter
  function automatic logic [TW-1:0] cnt_dec(input logic [TW-1:0] c);
    cnt_dec = c - TW'(1);
  endfunction

  // true in the last counted cycle, also for a zero load
  function automatic logic cnt_last(input logic [TW-1:0] c);
    cnt_last = (c <= TW'(1));
  endfunction

  // menu setting with 10 minute auto revert
  logic [1:0]  menu_reg;
  logic [39:0] mcnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      menu_reg <= MAINT_OFF;
      mcnt_reg <= '0;
    end else if (maint_set_stb_i) begin
      menu_reg <= (maint_set_val_i == MAINT_RSVD) ? MAINT_OFF : maint_set_val_i;
      mcnt_reg <= '0;
    end else if (menu_reg != MAINT_OFF) begin
      if (mcnt_reg >= MAINT_CYC - 40'h1) begin
        menu_reg <= MAINT_OFF;
        mcnt_reg <= '0;
      end else begin
        mcnt_reg <= mcnt_reg + 40'h1;
      end
    end
  end

  // input level holds mode without limit; menu selects block vs trips
  logic [1:0] mode;
  always_comb begin
    if (maint_in_assigned_i && maint_in_i)
      mode = (menu_reg == MAINT_BLOCK) ? MAINT_BLOCK : MAINT_TRIPS;
    else
      mode = menu_reg;
  end
  logic active;
  assign active = (mode != MAINT_OFF);
  assign maint_mode_o = mode;
  assign maint_active_o = active;
  assign report_en_o = !(active && proto_i == PROTO_MODBUS);
  assign report_maint_flag_o = active && proto_i == PROTO_IEC103;

  // output test timer
  logic [TW-1:0]      ot_cnt_reg;
  logic [NUM_OUT-1:0] ot_pat_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !active) begin
      ot_cnt_reg <= '0;
      ot_pat_reg <= '0;
    end else if (apply_test_i && test_pattern_i != '0 && test_time_i != '0) begin
      ot_cnt_reg <= test_time_i;
      ot_pat_reg <= test_pattern_i;
    end else if (ot_cnt_reg != '0) begin
      ot_cnt_reg <= cnt_dec(ot_cnt_reg);
      if (ot_cnt_reg == TW'(1)) ot_pat_reg <= '0;
    end
  end

  // functional test sequencer
  logic                ft_run_reg;
  logic [TW-1:0]       ft_cnt_reg;
  logic [$clog2(NUM_ELEM)-1:0] ft_sel_reg;
  logic                thclr_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !active) begin
      ft_run_reg <= 1'b0;
      ft_cnt_reg <= '0;
      ft_sel_reg <= '0;
      thclr_reg  <= 1'b0;
    end else begin
      thclr_reg <= 1'b0;
      if (!ft_run_reg && ftest_go_i && elem_enable_i[ftest_sel_i]) begin
        ft_run_reg <= 1'b1;
        ft_sel_reg <= ftest_sel_i;
        ft_cnt_reg <= test_time_i;
      end else if (ft_run_reg) begin
        if ((ftest_end_i == FEND_TRIP && elem_trip_i) ||
            (ftest_end_i == FEND_TIME && cnt_last(ft_cnt_reg))) begin
          ft_run_reg <= 1'b0;
          thclr_reg  <= (ft_sel_reg == THERMAL_IDX);
        end
        if (ft_cnt_reg != '0) ft_cnt_reg <= cnt_dec(ft_cnt_reg);
      end
    end
  end
  always_comb begin
    sim_elem_o = '0;
    if (ft_run_reg) sim_elem_o[ft_sel_reg] = 1'b1;
  end
  assign thermal_clr_o = thclr_reg;
  assign field_rec_o = 1'b1;

  // contacts and LEDs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      contact_o <= '0;
      led_o     <= '0;
    end else begin
      contact_o <= (mode == MAINT_BLOCK) ? '0 : (out_func_i | ot_pat_reg);
      led_o     <= led_func_i;
    end
  end

  // manual breaker control
  mtbc_cb_state_t cb_reg;
  logic [TW-1:0]  cb_cnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cb_reg     <= CB_IDLE;
      cb_cnt_reg <= '0;
    end else if (prot_trip_i && cb_reg != CB_LOCKOUT && cb_reg != CB_OPEN_PULSE) begin
      cb_reg     <= CB_IDLE;
      cb_cnt_reg <= '0;
    end else begin
      if (cb_cnt_reg != '0) cb_cnt_reg <= cnt_dec(cb_cnt_reg);
      case (cb_reg)
        CB_IDLE: begin
          if (man_trip_i && breaker_closed_aux_in_i && !breaker_open_aux_in_i) begin
            cb_reg     <= CB_OPEN_PULSE;
            cb_cnt_reg <= open_pulse_length_i;
          end else if (man_close_i && breaker_open_aux_in_i && !breaker_closed_aux_in_i) begin
            cb_reg     <= healthy_assigned_i ? CB_WAIT_HEALTHY : CB_CLOSE_DELAY;
            cb_cnt_reg <= healthy_assigned_i ? breaker_healthy_timeout_i : close_delay_i;
          end
        end
        CB_WAIT_HEALTHY: begin
          if (breaker_healthy_in_i) begin
            cb_reg     <= CB_CLOSE_DELAY;
            cb_cnt_reg <= close_delay_i;
          end else if (cb_cnt_reg <= TW'(1)) begin
            cb_reg <= CB_LOCKOUT;
          end
        end
        CB_CLOSE_DELAY: begin
          if (cb_cnt_reg <= TW'(1)) begin
            cb_reg     <= CB_CLOSE_PULSE;
            cb_cnt_reg <= close_pulse_length_i;
          end
        end
        CB_CLOSE_PULSE, CB_OPEN_PULSE: begin
          if (cnt_last(cb_cnt_reg)) cb_reg <= CB_IDLE;
        end
        CB_LOCKOUT: begin
          if (lockout_clr_i) cb_reg <= CB_IDLE;
        end
        default: cb_reg <= CB_IDLE;
      endcase
    end
  end
  assign breaker_open_command_out_o  = (cb_reg == CB_OPEN_PULSE);
  assign breaker_close_command_out_o = (cb_reg == CB_CLOSE_PULSE);
  assign cb_alarm_o = (cb_reg == CB_LOCKOUT);

  // checks
  blocked_contacts_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode == MAINT_BLOCK |=> contact_o == '0) else $error("contact under block");
  led_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |=> led_o == $past(led_func_i)) else $error("led lost");
  input_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    maint_in_assigned_i && maint_in_i |-> active) else $error("input hold");
  modbus_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    active && proto_i == PROTO_MODBUS |-> !report_en_o) else $error("report leak");
  test_abort_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !active |=> ot_pat_reg == '0 && !ft_run_reg) else $error("test not aborted");
  sequence close_req_s;
    cb_reg == CB_IDLE && man_close_i && !healthy_assigned_i && !prot_trip_i &&
    breaker_open_aux_in_i && !breaker_closed_aux_in_i;
  endsequence
  close_delay_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    close_req_s |=> !breaker_close_command_out_o) else $error("close too early");
  trip_refused_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cb_reg == CB_IDLE && !breaker_closed_aux_in_i |=> !breaker_open_command_out_o)
    else $error("trip while open");
  prot_priority_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    prot_trip_i && cb_reg == CB_CLOSE_DELAY |=> !breaker_close_command_out_o)
    else $error("close survived trip");

  // maintenance setting, revert and reporting
  menu_revert_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    menu_reg != MAINT_OFF && !maint_set_stb_i && mcnt_reg >= MAINT_CYC - 40'h1
    |=> menu_reg == MAINT_OFF) else $error("menu did not revert");
  write_take_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    maint_set_stb_i && maint_set_val_i != MAINT_RSVD
    |=> menu_reg == $past(maint_set_val_i)) else $error("setting not taken");
  input_ends_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !maint_in_i && menu_reg == MAINT_OFF |-> !active) else $error("mode outlived input");
  iec_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    active && proto_i == PROTO_IEC103 |-> report_en_o && report_maint_flag_o)
    else $error("iec report not flagged");

  // output test load and release
  test_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    active && apply_test_i && test_pattern_i != '0 && test_time_i != '0
    |=> ot_pat_reg == $past(test_pattern_i) && ot_cnt_reg == $past(test_time_i))
    else $error("test not loaded");
  test_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ot_cnt_reg == TW'(1) && !apply_test_i |=> ot_pat_reg == '0)
    else $error("test overran");

  // functional test start and thermal clear
  disabled_elem_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !ft_run_reg && ftest_go_i && !elem_enable_i[ftest_sel_i] |=> !ft_run_reg)
    else $error("disabled element tested");
  thermal_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    active && ft_run_reg && ft_sel_reg == THERMAL_IDX && ftest_end_i == FEND_TRIP &&
    elem_trip_i |=> thermal_clr_o) else $error("thermal not cleared");

  // manual trip pulse and close refusal
  sequence trip_req_s;
    cb_reg == CB_IDLE && man_trip_i && !prot_trip_i &&
    breaker_closed_aux_in_i && !breaker_open_aux_in_i;
  endsequence
  open_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    trip_req_s |=> breaker_open_command_out_o && cb_cnt_reg == $past(open_pulse_length_i))
    else $error("open pulse not started");
  close_refused_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cb_reg == CB_IDLE && man_close_i && !man_trip_i && !breaker_open_aux_in_i
    |=> cb_reg == CB_IDLE) else $error("close while not open");

  // healthy supervision and lockout
  healthy_timeout_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cb_reg == CB_WAIT_HEALTHY && !breaker_healthy_in_i && !prot_trip_i &&
    cb_cnt_reg <= TW'(1) |=> cb_alarm_o) else $error("no lockout on timeout");
  lockout_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cb_reg == CB_LOCKOUT && !lockout_clr_i |=> cb_alarm_o) else $error("lockout lost");
endmodule

// ### verif/mtbc_brk_model.sv
// circuit breaker model with auxiliary status contacts
`timescale 1ns/10ps
module mtbc_brk_model (
  input  wire logic clk_i,    // clock
  input  wire logic rst_i,    // sync reset, high
  input  wire logic open_i,   // trip order
  input  wire logic close_i,  // close order
  output logic      closed_o, // aux closed
  output logic      open_o    // aux open
);
  // mechanism follows the orders, starts open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      closed_o <= 1'h0;
    end else if (open_i) begin
      closed_o <= 1'h0;
    end else if (close_i) begin
      closed_o <= 1'h1;
    end
  end
  // aux contacts always opposite
  assign open_o = ~closed_o;
endmodule

// ### verif/mtbc_top_tb_top.sv
// self-checking bench of the maintenance, test and breaker block
`timescale 1ns/10ps
module mtbc_top_tb_top;
  import mtbc_pkg::*;
  localparam int MC = 100;
  logic clk = 1'h0, rst = 1'h1, mas = 1'h0, mi = 1'h0, stb = 1'h0, pr = 1'h0;
  logic app = 1'h0, fe = 1'h1, go = 1'h0, et = 1'h0, pt = 1'h0, mt = 1'h0;
  logic mcl = 1'h0, ha = 1'h0, hl = 1'h0, lc = 1'h0;
  logic [1:0]  sv = 2'h0;
  logic [2:0]  fs = 3'h0;
  logic [6:0]  of = 7'h0, tp = 7'h0, snap;
  logic [7:0]  lf = 8'h0, ee = 8'h0;
  logic [31:0] tt = 32'h5;
  wire  [1:0]  mm;
  wire  [6:0]  ct;
  wire  [7:0]  led, sim;
  wire         ma, re, rf, fr, tc, oc, cc, al, bcl, bop;
  wire  [4:0]  mon = {tc, al, cc, oc, |ct};
  int          num_errors = 0, checked = 0, cyc = 0, d, n;
  mtbc_top #(.MAINT_CYC(40'(MC))) dut (
    .core_clk_i(clk), .rst_i(rst), .maint_in_assigned_i(mas), .maint_in_i(mi),
    .maint_set_stb_i(stb), .maint_set_val_i(sv), .proto_i(pr), .out_func_i(of),
    .led_func_i(lf), .test_pattern_i(tp), .test_time_i(tt), .apply_test_i(app),
    .elem_enable_i(ee), .ftest_sel_i(fs), .ftest_end_i(fe), .ftest_go_i(go),
    .elem_trip_i(et), .prot_trip_i(pt), .man_trip_i(mt), .man_close_i(mcl),
    .breaker_closed_aux_in_i(bcl), .breaker_open_aux_in_i(bop),
    .healthy_assigned_i(ha), .breaker_healthy_in_i(hl), .lockout_clr_i(lc),
    .close_delay_i(32'h6), .open_pulse_length_i(32'h4),
    .close_pulse_length_i(32'h3), .breaker_healthy_timeout_i(32'ha),
    .maint_mode_o(mm), .maint_active_o(ma), .report_en_o(re),
    .report_maint_flag_o(rf), .contact_o(ct), .led_o(led), .sim_elem_o(sim),
    .field_rec_o(fr), .thermal_clr_o(tc), .breaker_open_command_out_o(oc),
    .breaker_close_command_out_o(cc), .cb_alarm_o(al));
  mtbc_brk_model brk (.clk_i(clk), .rst_i(rst), .open_i(oc), .close_i(cc),
    .closed_o(bcl), .open_o(bop));
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // one-cycle request pulse, raised and dropped at falling edges
  task automatic pls(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic wr(input logic [1:0] v);
    sv = v;
    pls(stb);
  endtask
  // bounded wait for a rise of one monitored output, then its length
  task automatic pulse(input int i, output int dl, output int ln);
    dl = 0;
    ln = 0;
    while (mon[i] !== 1'h1 && dl < 300) begin
      tick(1);
      dl++;
    end
    snap = ct;
    while (mon[i] === 1'h1 && ln < 300) begin
      tick(1);
      ln++;
    end
  endtask
  // main sequence
  initial begin
    tick(6);
    rst = 1'h0;
    tick(1);
    chk("mode", MAINT_OFF, mm);
    chk("report", 1, re);
    chk("field_rec", 1, fr);
    wr(MAINT_TRIPS);
    chk("mode", MAINT_TRIPS, mm);
    chk("active", 1, ma);
    chk("report", 0, re);
    pr = PROTO_IEC103;
    tick(1);
    chk("flag", 3, {re, rf});
    tp = 7'h25;
    pls(app);
    pulse(0, d, n);
    chk("pattern", 7'h25, snap);
    chk("test_len", 5, n);
    of = 7'h7f;
    lf = 8'h81;
    wr(MAINT_BLOCK);
    pls(app);
    tick(4);
    chk("blocked", 0, ct);
    chk("leds", 8'h81, led);
    of = 7'h0;
    tt = 50;
    wr(MAINT_TRIPS);
    pls(app);
    tick(4);
    wr(MAINT_OFF);
    tick(2);
    chk("abort", 0, ct);
    wr(MAINT_TRIPS);
    tick(MC - 10);
    chk("mode_held", MAINT_TRIPS, mm);
    tick(12);
    chk("mode_timeout", MAINT_OFF, mm);
    mas = 1'h1;
    mi = 1'h1;
    tick(MC + 20);
    chk("input_mode", MAINT_TRIPS, mm);
    mi = 1'h0;
    tick(2);
    chk("input_low", MAINT_OFF, mm);
    mi = 1'h1;
    tt = 5;
    ee = 8'h01;
    pls(go);
    chk("sim", 8'h01, sim);
    pulse(4, d, n);
    chk("thermal", 1, n);
    fs = 3'h1;
    ee = 8'h0;
    pls(go);
    tick(1);
    chk("disabled", 0, sim);
    ee = 8'h02;
    fe = FEND_TRIP;
    pls(go);
    tick(8);
    chk("trip_end_wait", 8'h02, sim);
    et = 1'h1;
    tick(3);
    chk("trip_end", 0, sim);
    et = 1'h0;
    mi = 1'h0;
    pls(mt);
    tick(10);
    chk("trip_refused", 0, oc);
    pls(mcl);
    pulse(2, d, n);
    chk("close_delay", 6, d);
    chk("close_len", 3, n);
    tick(2);
    pls(mt);
    pulse(1, d, n);
    chk("open_len", 4, n);
    tick(2);
    pls(mcl);
    tick(3);
    pt = 1'h1;
    pulse(2, d, n);
    chk("cancel", 0, n);
    pt = 1'h0;
    ha = 1'h1;
    pls(mcl);
    tick(15);
    chk("lockout", 2, {al, cc});
    pls(lc);
    tick(1);
    chk("lockout_clr", 0, al);
    hl = 1'h1;
    pls(mcl);
    pulse(2, d, n);
    chk("healthy_close", 7, d);
    chk("healthy_len", 3, n);
    wr(MAINT_TRIPS);
    wr(MAINT_RSVD);
    chk("code3_off", MAINT_OFF, mm);
    test_done();
  end
endmodule
